// *** hw/pcc_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module pcc_ctrl
	import pcc_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [2:0] page_selector,
	input wire logic mgmt_wr,
	input wire logic mgmt_rd,
	input wire logic [4:0] mgmt_addr,
	input wire logic [15:0] mgmt_wdata,
	output logic [15:0] mgmt_rdata_ff,
	output logic mgmt_rvalid_ff,
	output logic [31:0] time_sec_ff,
	output logic [31:0] time_ns_ff,
	output logic clock_run_enable_ff,
	output logic clock_reset_hold_ff,
	output logic [PCC_NTRIG-1:0] trig_enabled_ff
);
	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic [2:0] trigger_index_select_ff; // chosen trigger
	logic [2:0] cmd_sel; // index carried by this control write
	pcc_mode_e mode_ff; // data port function
	logic [2:0] ptr_ff; // word index on the data port
	logic [63:0] stage_ff; // staged time or offset {sec,ns}
	logic [63:0] sample_ff; // captured time {sec,ns}
	logic [15:0] mem_q; // field word at {index,ptr}
	logic page_ok; // registers visible on this page
	logic ctl_wr, ctl_rd, tdp_wr, tdp_rd; // register strobes
	logic cmd_ok; // commands allowed, logic not held
	logic c_tdis, c_ten, c_read, c_prog; // trigger commands
	logic c_sample, c_set, c_adj, c_run, c_stop; // clock commands
	logic load_last; // final field written during load
	logic [31:0] adj_ns; // ns sum during adjust
	logic [15:0] ctl_view; // control register read value
	logic [15:0] tdp_view; // data port read value

	assign page_ok = (page_selector == PCC_PAGE_SYNC);
	assign ctl_wr = mgmt_wr && page_ok && (mgmt_addr == PCC_OFS_CTL);
	assign ctl_rd = mgmt_rd && page_ok && (mgmt_addr == PCC_OFS_CTL);
	assign tdp_wr = mgmt_wr && page_ok && (mgmt_addr == PCC_OFS_TDP);
	assign tdp_rd = mgmt_rd && page_ok && (mgmt_addr == PCC_OFS_TDP);
	assign cmd_ok = ctl_wr && !clock_reset_hold_ff;
	// commands act on the index written with them, not the old one
	assign cmd_sel = mgmt_wdata[PCC_B_SEL_LO +: 3];
	assign c_tdis = cmd_ok && mgmt_wdata[PCC_B_TDIS];
	assign c_ten = cmd_ok && mgmt_wdata[PCC_B_TEN];
	assign c_read = cmd_ok && mgmt_wdata[PCC_B_READ];
	assign c_prog = cmd_ok && mgmt_wdata[PCC_B_PROG];
	assign c_sample = cmd_ok && mgmt_wdata[PCC_B_SAMPLE];
	assign c_set = cmd_ok && mgmt_wdata[PCC_B_SET];
	assign c_adj = cmd_ok && mgmt_wdata[PCC_B_ADJ];
	assign c_run = cmd_ok && mgmt_wdata[PCC_B_RUN];
	assign c_stop = cmd_ok && mgmt_wdata[PCC_B_STOP];
	assign load_last = tdp_wr && (mode_ff == PCC_MODE_LOAD) &&
		(ptr_ff == PCC_TRIG_FIELDS - 3'h1);

	// ----------------------------------------------------------------
	// control register state
	// ----------------------------------------------------------------
	// index field
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			trigger_index_select_ff <= PCC_SEL_RST;
		end else if (ctl_wr) begin
			trigger_index_select_ff <= mgmt_wdata[PCC_B_SEL_LO +: 3];
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			clock_reset_hold_ff <= 1'b0;
		end else if (ctl_wr) begin
			clock_reset_hold_ff <= mgmt_wdata[PCC_B_RESET];
		end
	end

	// run state; stop wins over run
	always_ff @(posedge core_clk) begin
		if (sys_rst || clock_reset_hold_ff) begin
			clock_run_enable_ff <= 1'b0;
		end else if (c_stop) begin
			clock_run_enable_ff <= 1'b0;
		end else if (c_run) begin
			clock_run_enable_ff <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// triggers
	// ----------------------------------------------------------------
	// enable state gates nothing; pin drive stays outside
	genvar g;
	generate
		for (g = 0; g < PCC_NTRIG; g++) begin : g_trig
			always_ff @(posedge core_clk) begin
				if (sys_rst || clock_reset_hold_ff) begin
					trig_enabled_ff[g] <= 1'b0;
				end else if (cmd_ok && cmd_sel == 3'(g)) begin
					if (c_tdis) begin
						trig_enabled_ff[g] <= 1'b0;
					end else if (c_ten) begin
						trig_enabled_ff[g] <= 1'b1;
					end else if (c_prog) begin
						trig_enabled_ff[g] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// data port mode
	always_ff @(posedge core_clk) begin
		if (sys_rst || clock_reset_hold_ff) begin
			mode_ff <= PCC_MODE_TIME;
		end else if (c_prog && !c_ten) begin
			mode_ff <= PCC_MODE_LOAD;
		end else if (c_read) begin
			mode_ff <= PCC_MODE_READ;
		end else if (c_sample) begin
			mode_ff <= PCC_MODE_SAMPLE;
		end else if ((c_ten && mode_ff == PCC_MODE_LOAD) || c_set || c_adj) begin
			mode_ff <= PCC_MODE_TIME;
		end else if (load_last) begin
			mode_ff <= PCC_MODE_TIME;
		end
	end

	// word pointer, restarts on any command except run and stop, saturates
	always_ff @(posedge core_clk) begin
		if (sys_rst || clock_reset_hold_ff) begin
			ptr_ff <= 3'h0;
		end else if (cmd_ok && mgmt_wdata[PCC_B_TDIS:PCC_B_ADJ] != 7'h00) begin
			ptr_ff <= 3'h0;
		end else if (load_last) begin
			ptr_ff <= 3'h0;
		end else if ((tdp_wr || tdp_rd) && ptr_ff != PCC_PTR_MAX) begin
			ptr_ff <= ptr_ff + 3'h1;
		end
	end

	pcc_trig_mem u_mem (
		.core_clk(core_clk),
		.wr_en(tdp_wr && mode_ff == PCC_MODE_LOAD),
		.wr_addr({trigger_index_select_ff, ptr_ff}),
		.wr_data(mgmt_wdata),
		.rd_addr({trigger_index_select_ff, ptr_ff}),
		.rd_data_ff(mem_q)
	);

	// ----------------------------------------------------------------
	// time clock
	// ----------------------------------------------------------------
	// staging words: ns low, ns high, sec low, sec high
	always_ff @(posedge core_clk) begin
		if (sys_rst || clock_reset_hold_ff) begin
			stage_ff <= 64'h0;
		end else if (tdp_wr && mode_ff == PCC_MODE_TIME &&
				ptr_ff < PCC_TIME_WORDS) begin
			stage_ff[{ptr_ff[1:0], 4'h0} +: 16] <= mgmt_wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst || clock_reset_hold_ff) begin
			sample_ff <= 64'h0;
		end else if (c_sample) begin
			sample_ff <= {time_sec_ff, time_ns_ff};
		end
	end

	// offset sum, ns kept below one second
	assign adj_ns = time_ns_ff + stage_ff[31:0];

	always_ff @(posedge core_clk) begin
		if (sys_rst || clock_reset_hold_ff) begin
			time_sec_ff <= 32'h0;
			time_ns_ff <= 32'h0;
		end else if (c_set) begin
			time_sec_ff <= stage_ff[63:32];
			time_ns_ff <= stage_ff[31:0];
		end else if (c_adj) begin
			if (adj_ns >= PCC_NS_PER_SEC) begin
				time_ns_ff <= adj_ns - PCC_NS_PER_SEC;
				time_sec_ff <= time_sec_ff + stage_ff[63:32] + 32'h1;
			end else begin
				time_ns_ff <= adj_ns;
				time_sec_ff <= time_sec_ff + stage_ff[63:32];
			end
		end else if (clock_run_enable_ff) begin
			if (time_ns_ff + PCC_NS_INC >= PCC_NS_PER_SEC) begin
				time_ns_ff <= time_ns_ff + PCC_NS_INC - PCC_NS_PER_SEC;
				time_sec_ff <= time_sec_ff + 32'h1;
			end else begin
				time_ns_ff <= time_ns_ff + PCC_NS_INC;
			end
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// upper bits and command bits read zero, except bit 6 shows load mode, bit 2 the run state and bit 0 the hold
	assign ctl_view = {3'h0, trigger_index_select_ff, 3'h0,
		(mode_ff == PCC_MODE_LOAD), 3'h0, clock_run_enable_ff, 1'b0,
		clock_reset_hold_ff};

	// data port words, zero past the end
	always_comb begin
		tdp_view = 16'h0000;
		unique case (mode_ff)
			PCC_MODE_READ: begin
				if (ptr_ff < PCC_TRIG_FIELDS) begin
					tdp_view = mem_q;
				end
			end
			PCC_MODE_SAMPLE: begin
				if (ptr_ff < PCC_TIME_WORDS) begin
					tdp_view = sample_ff[{ptr_ff[1:0], 4'h0} +: 16];
				end
			end
			PCC_MODE_TIME, PCC_MODE_LOAD: begin
				tdp_view = 16'h0000;
			end
		endcase
	end

	// read data register, zero for any other address or page
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			mgmt_rdata_ff <= PCC_RDATA_RST;
			mgmt_rvalid_ff <= 1'b0;
		end else begin
			mgmt_rvalid_ff <= mgmt_rd;
			if (ctl_rd) begin
				mgmt_rdata_ff <= ctl_view;
			end else if (tdp_rd) begin
				mgmt_rdata_ff <= tdp_view;
			end else if (mgmt_rd) begin
				mgmt_rdata_ff <= 16'h0000;
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	index_write_a: assert property (ctl_wr |=>
		trigger_index_select_ff == $past(mgmt_wdata[12:10]))
		else $error("index not taken");
	trig_disable_a: assert property (c_tdis |=>
		!trig_enabled_ff[trigger_index_select_ff])
		else $error("trigger not disabled");
	trig_enable_a: assert property (c_ten && !c_tdis |=>
		trig_enabled_ff[trigger_index_select_ff])
		else $error("trigger not enabled");
	load_start_a: assert property (c_prog && !c_ten |=>
		mode_ff == PCC_MODE_LOAD && ptr_ff == 3'h0)
		else $error("load not started");
	load_done_a: assert property (load_last |=>
		mode_ff == PCC_MODE_TIME && ptr_ff == 3'h0)
		else $error("load not finished");
	sample_take_a: assert property (c_sample |=>
		sample_ff == $past({time_sec_ff, time_ns_ff}))
		else $error("sample wrong");
	set_load_a: assert property (c_set |=>
		{time_sec_ff, time_ns_ff} == $past(stage_ff))
		else $error("set wrong");
	run_start_a: assert property (c_run && !c_stop |=>
		clock_run_enable_ff)
		else $error("clock not running");
	run_stop_a: assert property (c_stop |=>
		!clock_run_enable_ff [*2] or ctl_wr)
		else $error("clock not stopped");
	hold_clear_a: assert property (clock_reset_hold_ff |=>
		time_ns_ff == 32'h0 && !clock_run_enable_ff)
		else $error("hold did not clear");
	hold_keep_a: assert property (clock_reset_hold_ff && !ctl_wr |=>
		clock_reset_hold_ff)
		else $error("hold self-cleared");
	ctl_upper_a: assert property (ctl_rd |=>
		mgmt_rdata_ff[15:13] == 3'h0 && mgmt_rdata_ff[9:7] == 3'h0)
		else $error("reserved bits set");
	past_end_a: assert property (tdp_rd && mode_ff == PCC_MODE_SAMPLE &&
		ptr_ff >= PCC_TIME_WORDS |=> mgmt_rdata_ff == 16'h0000)
		else $error("read past end not zero");
	page_gate_a: assert property (mgmt_rd && !page_ok |=>
		mgmt_rdata_ff == 16'h0000 && mgmt_rvalid_ff)
		else $error("off-page read not zero");
endmodule : pcc_ctrl
`default_nettype wire

// *** shared/pcc_pkg.sv ***
// ----------------------------------------------------------------
// shared constants for the time-sync control block
// ----------------------------------------------------------------
package pcc_pkg;
	// page selector code that opens the time-sync base registers
	localparam logic [2:0] PCC_PAGE_SYNC = 3'h4;
	// register offsets
	localparam logic [4:0] PCC_OFS_CTL = 5'h14;
	localparam logic [4:0] PCC_OFS_TDP = 5'h15;
	// control register bit positions
	localparam int PCC_B_RESET = 0;
	localparam int PCC_B_STOP = 1;
	localparam int PCC_B_RUN = 2;
	localparam int PCC_B_ADJ = 3;
	localparam int PCC_B_SET = 4;
	localparam int PCC_B_SAMPLE = 5;
	localparam int PCC_B_PROG = 6;
	localparam int PCC_B_READ = 7;
	localparam int PCC_B_TEN = 8;
	localparam int PCC_B_TDIS = 9;
	localparam int PCC_B_SEL_LO = 10;
	// reset values
	localparam logic [2:0] PCC_SEL_RST = 3'h0;
	localparam logic [15:0] PCC_RDATA_RST = 16'h0000;
	// trigger store geometry
	localparam int PCC_NTRIG = 8;
	localparam logic [2:0] PCC_TRIG_FIELDS = 3'h6;
	localparam logic [2:0] PCC_TIME_WORDS = 3'h4;
	localparam logic [2:0] PCC_PTR_MAX = 3'h7;
	// time clock step per core cycle, derived from the 200 MHz period
	localparam int PCC_CLK_PERIOD_NS = 5;
	localparam logic [31:0] PCC_NS_INC = 32'(PCC_CLK_PERIOD_NS);
	localparam logic [31:0] PCC_NS_PER_SEC = 32'h3b9a_ca00;
	// what the data port currently serves
	typedef enum logic [1:0] {
		PCC_MODE_TIME = 2'b00,
		PCC_MODE_LOAD = 2'b01,
		PCC_MODE_READ = 2'b10,
		PCC_MODE_SAMPLE = 2'b11
	} pcc_mode_e;
endpackage : pcc_pkg

// *** hw/pcc_trig_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// trigger control field store, registered read
// ----------------------------------------------------------------
module pcc_trig_mem (
	input wire logic core_clk,
	input wire logic wr_en,
	input wire logic [5:0] wr_addr,
	input wire logic [15:0] wr_data,
	input wire logic [5:0] rd_addr,
	output logic [15:0] rd_data_ff
);
	// one word per field per trigger
	logic [15:0] mem [0:63];

	// write port
	always_ff @(posedge core_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// read port, one cycle latency
	always_ff @(posedge core_clk) begin
		rd_data_ff <= mem[rd_addr];
	end
endmodule : pcc_trig_mem
`default_nettype wire

// *** tb/pcc_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// management host model: one access at a time
// ----------------------------------------------------------------
module pcc_host (
	input wire logic core_clk,
	output logic [2:0] page_selector,
	output logic mgmt_wr,
	output logic mgmt_rd,
	output logic [4:0] mgmt_addr,
	output logic [15:0] mgmt_wdata,
	input wire logic [15:0] mgmt_rdata_ff,
	input wire logic mgmt_rvalid_ff
);
	// idle bus at time zero
	initial begin
		page_selector = 3'h4;
		mgmt_wr = 1'b0;
		mgmt_rd = 1'b0;
		mgmt_addr = 5'h00;
		mgmt_wdata = 16'h0000;
	end
	// page selector level
	task automatic page(input logic [2:0] p);
		page_selector = p;
	endtask : page
	// one write strobe; released lines flip so no stale value lingers
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge core_clk);
		#1;
		mgmt_addr = a;
		mgmt_wdata = d;
		mgmt_wr = 1'b1;
		@(posedge core_clk);
		#1;
		mgmt_wr = 1'b0;
		mgmt_addr = ~a;
		mgmt_wdata = ~d;
	endtask : wr
	// one read strobe, answer taken within a bounded wait
	task automatic rd(input logic [4:0] a, output logic [15:0] d,
		output bit ok);
		int i;
		ok = 1'b0;
		d = 16'h0000;
		@(posedge core_clk);
		#1;
		mgmt_addr = a;
		mgmt_rd = 1'b1;
		@(posedge core_clk);
		#1;
		mgmt_rd = 1'b0;
		mgmt_addr = ~a;
		for (i = 0; i < 4 && !ok; i++) begin
			if (mgmt_rvalid_ff === 1'b1) begin
				d = mgmt_rdata_ff;
				ok = 1'b1;
			end else begin
				@(posedge core_clk);
				#1;
			end
		end
	endtask : rd
endmodule : pcc_host
`default_nettype wire

// *** tb/ptp_clock_trigger_control_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// bench top: host model drives the block, integer model checks it
// ----------------------------------------------------------------
module ptp_clock_trigger_control_tb_top;
	import pcc_pkg::*;
	logic core_clk, sys_rst, mgmt_wr, mgmt_rd, mgmt_rvalid_ff, run, hold;
	logic [2:0] page_selector;
	logic [4:0] mgmt_addr;
	logic [15:0] mgmt_wdata, mgmt_rdata_ff, rv;
	logic [31:0] sec, ns, n0;
	logic [7:0] ten;
	int n_fail, tests_run, seed, t, k, n, p;
	bit ok;
	longint m_sec, m_ns; // model time
	int tf[8][6]; // model trigger fields
	logic [7:0] m_en; // model trigger enables
	localparam logic [4:0] C = PCC_OFS_CTL;
	localparam logic [4:0] D = PCC_OFS_TDP;
	pcc_host u_host (.core_clk(core_clk), .page_selector(page_selector),
		.mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_addr(mgmt_addr),
		.mgmt_wdata(mgmt_wdata), .mgmt_rdata_ff(mgmt_rdata_ff),
		.mgmt_rvalid_ff(mgmt_rvalid_ff));
	pcc_ctrl u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.page_selector(page_selector), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
		.mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata),
		.mgmt_rdata_ff(mgmt_rdata_ff), .mgmt_rvalid_ff(mgmt_rvalid_ff),
		.time_sec_ff(sec), .time_ns_ff(ns), .clock_run_enable_ff(run),
		.clock_reset_hold_ff(hold), .trig_enabled_ff(ten));
	// 200 MHz clock
	initial core_clk = 1'b0;
	always #2.5 core_clk = ~core_clk;
	// ----------------------------------------------------------------
	// checks and closing
	// ----------------------------------------------------------------
	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// read a register and compare, a lost answer ends the run
	task automatic rdc(input logic [4:0] a, input logic [15:0] e);
		u_host.rd(a, rv, ok);
		if (!ok) begin
			n_fail++;
			$display("mismatch t=%0t no read answer", $time);
			results();
		end
		chk({16'h0, rv}, {16'h0, e});
	endtask : rdc
	// time outputs and enables against the model, one edge settled
	task automatic chk_st();
		@(posedge core_clk);
		#1;
		chk(sec, m_sec[31:0]);
		chk(ns, m_ns[31:0]);
		chk({24'h0, ten}, {24'h0, m_en});
	endtask : chk_st
	task automatic put_t(input logic [31:0] s, input logic [31:0] v);
		u_host.wr(D, v[15:0]);
		u_host.wr(D, v[31:16]);
		u_host.wr(D, s[15:0]);
		u_host.wr(D, s[31:16]);
	endtask : put_t
	// watchdog
	initial begin
		#400000;
		n_fail++;
		$display("mismatch t=%0t run too long", $time);
		results();
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 32'hfaa6;
		n_fail = 0;
		tests_run = 0;
		m_en = 8'h00;
		sys_rst = 1'b1;
		repeat (3) @(posedge core_clk);
		#1;
		sys_rst = 1'b0;
		m_sec = 0;
		m_ns = 0;
		rdc(C, 16'h0000);
		u_host.wr(C, 16'hfc01);
		rdc(C, 16'h1c01);
		rdc(C, 16'h1c01);
		u_host.wr(C, 16'h0000);
		rdc(C, 16'h0000);
		$display("test control done");
		// set, then adjust with a nanosecond carry
		m_sec = $random(seed) & 32'hffff_ffff;
		m_ns = ($random(seed) & 32'h0fff_ffff) | 32'h1;
		put_t(m_sec[31:0], m_ns[31:0]);
		u_host.wr(C, 16'h0010);
		chk_st();
		n0 = $random(seed) & 32'h0000_ffff;
		put_t(n0, 32'd999_999_999);
		u_host.wr(C, 16'h0008);
		m_sec = (m_sec + n0 + 1) & 32'hffff_ffff;
		m_ns = m_ns + 999_999_999 - 1_000_000_000;
		chk_st();
		u_host.wr(C, 16'h0020);
		rdc(D, m_ns[15:0]);
		rdc(D, m_ns[31:16]);
		rdc(D, m_sec[15:0]);
		rdc(D, m_sec[31:16]);
		rdc(D, 16'h0000);
		$display("test time done");
		// run, write of zero ignored, stop
		u_host.wr(C, 16'h0004);
		rdc(C, 16'h0004);
		n0 = ns;
		repeat (10) @(posedge core_clk);
		#1;
		chk(ns - n0, 32'd10 * PCC_NS_INC);
		u_host.wr(C, 16'h0000);
		rdc(C, 16'h0004);
		u_host.wr(C, 16'h0002);
		rdc(C, 16'h0000);
		n0 = ns;
		repeat (5) @(posedge core_clk);
		#1;
		chk(ns - n0, 32'h0);
		// back to the model time: a set returns the port to time mode
		u_host.wr(C, 16'h0010);
		put_t(m_sec[31:0], m_ns[31:0]);
		u_host.wr(C, 16'h0010);
		chk_st();
		$display("test run done");
		// triggers: full loads, then partial loads on odd triggers ended by enable
		for (p = 0; p < 2; p++) begin
			for (t = 0; t < 8; t++) begin
				u_host.wr(C, 16'(t << 10) | 16'h0100);
				m_en[t] = 1'b1;
				chk_st();
				u_host.wr(C, 16'(t << 10) | 16'h0040);
				m_en[t] = 1'b0;
				rdc(C, 16'(t << 10) | 16'h0040);
				n = (p == 1 && t % 2 == 1) ? 3 : 6;
				for (k = 0; k < n; k++) begin
					tf[t][k] = $random(seed) & 16'hffff;
					u_host.wr(D, tf[t][k][15:0]);
				end
				if (n == 3) begin
					u_host.wr(C, 16'(t << 10) | 16'h0100);
					m_en[t] = 1'b1;
				end
				rdc(C, 16'(t << 10));
				chk_st();
				u_host.wr(C, 16'(t << 10) | 16'h0080);
				for (k = 0; k < 7; k++) begin
					rdc(D, k < 6 ? tf[t][k][15:0] : 16'h0000);
				end
				u_host.wr(C, 16'(t << 10) | 16'h0200);
				m_en[t] = 1'b0;
				chk_st();
			end
		end
		$display("test trigger done");
		// hold bit clears the clock and blocks commands
		u_host.wr(C, 16'h1504);
		u_host.wr(C, 16'h0001);
		m_sec = 0;
		m_ns = 0;
		chk_st();
		u_host.wr(C, 16'h0105);
		chk_st();
		rdc(C, 16'h0001);
		chk({31'h0, hold}, 32'h1);
		u_host.wr(C, 16'h0000);
		rdc(C, 16'h0000);
		$display("test hold done");
		// off-page accesses are refused
		u_host.page(3'h0);
		u_host.wr(C, 16'h0004);
		rdc(C, 16'h0000);
		u_host.page(3'h4);
		rdc(C, 16'h0000);
		chk({31'h0, run}, 32'h0);
		$display("test page done");
		results();
	end
endmodule : ptp_clock_trigger_control_tb_top
`default_nettype wire
